//--- src/trr_pkg.sv
// Package: constants and types for the tape rewind/ready logic
`default_nettype none
package trr_pkg;
    // Rewind pulse limits in nanoseconds
    localparam int REW_PULSE_MIN_NS = 500;
    localparam int REW_PULSE_MAX_NS = 5000;
    localparam int CLK_PERIOD_NS = 10;
    // Shortest allowed low pulse in clock cycles, rounded up (50 cycles)
    localparam int REW_MIN_CYC_I =
        (REW_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] REW_MIN_CYC = REW_MIN_CYC_I[9:0];
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [9:0] CNT_ONE = 10'h001;
    // Status and mask bit positions
    localparam int EV_LOAD = 0;
    localparam int EV_REW_START = 1;
    localparam int EV_READY = 2;
    localparam int EV_MARK = 3;
    localparam int EV_W = 4;
    localparam logic [EV_W-1:0] EV_NONE = 4'h0;
    // Register indexes of the command port
    localparam logic [1:0] ADR_STATUS = 2'h0;
    localparam logic [1:0] ADR_MASK = 2'h1;
    localparam logic [1:0] ADR_STATE = 2'h2;
    localparam logic [7:0] RD_ZERO = 8'h00;
    // Motion state, one-hot
    typedef enum logic [3:0] {
        ST_EMPTY = 4'h1,
        ST_REWIND = 4'h2,
        ST_READY = 4'h4,
        ST_IDLE = 4'h8
    } trr_state_e;
endpackage : trr_pkg
`default_nettype wire

//--- src/trr_sync_if.sv
// Interface: synchronised pin levels passed from the sampler to the core
`default_nettype none
interface trr_sync_if;
    logic cartPresent;
    logic writeTab;
    logic leaderSeen;
    logic holeSeen;
    logic rewindPulse_n;
    logic unitSelect_n;
    logic hostReadyLamp_n;
    logic fastSpeedReq_n;
    logic fwdReq_n;
    logic bwdReq_n;
    modport src (output cartPresent, writeTab, leaderSeen, holeSeen,
        rewindPulse_n, unitSelect_n, hostReadyLamp_n, fastSpeedReq_n,
        fwdReq_n, bwdReq_n);
    modport dst (input cartPresent, writeTab, leaderSeen, holeSeen,
        rewindPulse_n, unitSelect_n, hostReadyLamp_n, fastSpeedReq_n,
        fwdReq_n, bwdReq_n);
endinterface : trr_sync_if
`default_nettype wire

//--- src/trr_pin_sync.sv
// Module: two-flop synchronisers for all pin inputs
`default_nettype none
module trr_pin_sync
    import trr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [9:0] pins,
    trr_sync_if.src syncOut
);
    // ------------------------------------------------------------
    // Synchroniser state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [9:0] stage1; // First flop, read only by stage2
        logic [9:0] stage2; // Second flop, safe to use
    } trr_sync_s;

    trr_sync_s cur;
    trr_sync_s next_cur;

    // Idle pin levels: all inactive-low lines high, sensors low
    localparam logic [9:0] PIN_IDLE = 10'h3F0;

    // Shift pins through two flops
    always_comb begin
        next_cur.stage1 = pins;
        next_cur.stage2 = cur.stage1;
    end

    // Reset to idle (inactive-low lines high)
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cur <= {PIN_IDLE, PIN_IDLE};
        end else begin
            cur <= next_cur;
        end
    end

    assign syncOut.cartPresent = cur.stage2[0];
    assign syncOut.writeTab = cur.stage2[1];
    assign syncOut.leaderSeen = cur.stage2[2];
    assign syncOut.holeSeen = cur.stage2[3];
    assign syncOut.rewindPulse_n = cur.stage2[4];
    assign syncOut.unitSelect_n = cur.stage2[5];
    assign syncOut.hostReadyLamp_n = cur.stage2[6];
    assign syncOut.fastSpeedReq_n = cur.stage2[7];
    assign syncOut.fwdReq_n = cur.stage2[8];
    assign syncOut.bwdReq_n = cur.stage2[9];
endmodule : trr_pin_sync
`default_nettype wire

//--- src/tape_rewind_ready_logic.sv
// Module: status, rewind and ready logic of a cartridge tape drive
`default_nettype none
module tape_rewind_ready_logic
    import trr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    // Sensor inputs
    input wire logic cartSense,
    input wire logic tabSense,
    input wire logic leaderSense,
    input wire logic holeSense,
    // Interface inputs from the controlling device
    input wire logic rewind_pulse_n,
    input wire logic unit_select_n,
    input wire logic host_ready_lamp_level_n,
    input wire logic fast_speed_req_n,
    input wire logic fwdReq_n,
    input wire logic bwdReq_n,
    // Register port
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    output logic irq,
    // Status outputs
    output logic ready_lamp_n,
    output logic write_lamp_level_n,
    output logic write_tab_level,
    output logic cartridge_present,
    output logic leader_absent_n,
    output logic photo_position_sense,
    output logic mark_seen_pulse,
    output logic fast_speed_n,
    output logic drive_ready_n,
    output logic reverse_motor_control,
    output logic fwdDriveGated,
    output logic bwdDriveGated
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    trr_sync_if syncBus ();

    trr_pin_sync uSync (
        .ref_clk (ref_clk),
        .reset (reset),
        .pins ({bwdReq_n, fwdReq_n, fast_speed_req_n,
            host_ready_lamp_level_n, unit_select_n, rewind_pulse_n,
            holeSense, leaderSense, tabSense, cartSense}),
        .syncOut (syncBus)
    );

    // ------------------------------------------------------------
    // State of the block
    // ------------------------------------------------------------
    typedef struct packed {
        trr_state_e state;          // Motion state
        logic cartPrev;             // Cartridge level last cycle
        logic rewPrev;              // Rewind line last cycle
        logic posPrev;              // Position sense last cycle
        logic [9:0] lowCnt;         // Length of current rewind low
        logic [EV_W-1:0] status;    // Sticky event bits
        logic [EV_W-1:0] mask;      // Interrupt enables
        logic [7:0] rdData;         // Read data register
        logic irq;                  // Interrupt output
        logic readyLamp_n;          // Ready lamp drive
        logic writeLamp_n;          // Write lamp drive
        logic writeTab;             // Write tab level
        logic cartPresent;          // Cartridge present level
        logic leaderAbsent_n;       // Clear leader level
        logic posSense;             // Position sense level
        logic markPulse;            // Mark sensed pulse
        logic fastSpeed_n;          // Internal high speed
        logic driveReady_n;         // Ready to host
        logic reverseMotor;         // Reverse motor control
        logic fwdGated;             // Forward drive enable
        logic bwdGated;             // Backward drive enable
    } trr_core_s;

    trr_core_s cur;
    trr_core_s next_cur;

    // Decode a selected register index
    function automatic logic isAddr(input logic [1:0] a,
        input logic [1:0] want);
        isAddr = (a == want);
    endfunction

    // Working terms
    logic selected;
    logic posNow;
    logic rewEdge;
    logic loadEvt;
    logic [EV_W-1:0] events;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        selected = !syncBus.unitSelect_n;
        // Leader or hole lights the sensor
        posNow = syncBus.leaderSeen | syncBus.holeSeen;
        // Falling edge of rewind line while selected
        rewEdge = selected && cur.rewPrev && !syncBus.rewindPulse_n;
        loadEvt = syncBus.cartPresent && !cur.cartPrev;
        events = EV_NONE;

        next_cur.cartPrev = syncBus.cartPresent;
        next_cur.rewPrev = syncBus.rewindPulse_n;
        next_cur.posPrev = posNow;

        // Measure low time up to REW_MIN_CYC; a too-short glitch is neither noted nor rejected
        if (!syncBus.rewindPulse_n) begin
            if (cur.lowCnt != REW_MIN_CYC) begin
                next_cur.lowCnt = cur.lowCnt + CNT_ONE;
            end
        end else begin
            next_cur.lowCnt = CNT_ZERO;
        end

        // Plain sensor levels
        next_cur.cartPresent = syncBus.cartPresent;
        next_cur.writeTab = syncBus.cartPresent
            && syncBus.writeTab;
        next_cur.writeLamp_n = !(syncBus.cartPresent
            && syncBus.writeTab);
        next_cur.leaderAbsent_n = !syncBus.leaderSeen;
        next_cur.posSense = posNow;
        // Hole seen without leader marks the tape position
        next_cur.markPulse = posNow && !cur.posPrev
            && !syncBus.leaderSeen;
        next_cur.fastSpeed_n = !(selected
            && !syncBus.fastSpeedReq_n);
        // Lamp follows host level only
        next_cur.readyLamp_n = syncBus.hostReadyLamp_n;

        // Motion state machine
        case (cur.state)
            ST_EMPTY: begin
                if (syncBus.cartPresent) begin
                    events[EV_LOAD] = 1'b1;
                    if (syncBus.leaderSeen) begin
                        next_cur.state = ST_READY;
                    end else begin
                        next_cur.state = ST_REWIND;
                        events[EV_REW_START] = 1'b1;
                    end
                end
            end
            ST_REWIND: begin
                if (!syncBus.cartPresent) begin
                    next_cur.state = ST_EMPTY;
                end else if (syncBus.leaderSeen) begin
                    next_cur.state = ST_READY;
                    events[EV_READY] = 1'b1;
                end
            end
            ST_READY, ST_IDLE: begin
                if (!syncBus.cartPresent) begin
                    next_cur.state = ST_EMPTY;
                end else if (rewEdge && !syncBus.leaderSeen) begin
                    next_cur.state = ST_REWIND;
                    events[EV_REW_START] = 1'b1;
                end
            end
            default: begin
                next_cur.state = ST_EMPTY;
            end
        endcase
        if (loadEvt && cur.state != ST_EMPTY) begin
            events[EV_LOAD] = 1'b1;
        end
        if (next_cur.markPulse) begin
            events[EV_MARK] = 1'b1;
        end

        // Ready and reverse motor, gated by unit select
        next_cur.reverseMotor = (next_cur.state == ST_REWIND)
            && syncBus.cartPresent && selected;
        next_cur.driveReady_n = !((next_cur.state == ST_READY)
            && selected);
        // Drive requests blocked while rewinding
        next_cur.fwdGated = selected && !syncBus.fwdReq_n
            && syncBus.cartPresent
            && next_cur.state == ST_READY;
        next_cur.bwdGated = selected && !syncBus.bwdReq_n
            && syncBus.cartPresent && !syncBus.leaderSeen
            && next_cur.state == ST_READY;

        // Register writes; set wins over clear
        if (regWrite && isAddr(regAddr, ADR_MASK)) begin
            next_cur.mask = regWrData[EV_W-1:0];
        end
        if (regWrite && isAddr(regAddr, ADR_STATUS)) begin
            next_cur.status = (cur.status & ~regWrData[EV_W-1:0])
                | events;
        end else begin
            next_cur.status = cur.status | events;
        end

        // Register reads, data next cycle
        next_cur.rdData = RD_ZERO;
        if (regRead) begin
            if (isAddr(regAddr, ADR_STATUS)) begin
                next_cur.rdData = {4'h0, cur.status};
            end else if (isAddr(regAddr, ADR_MASK)) begin
                next_cur.rdData = {4'h0, cur.mask};
            end else if (isAddr(regAddr, ADR_STATE)) begin
                next_cur.rdData = {cur.state, 1'b0,
                    cur.reverseMotor, cur.driveReady_n,
                    cur.cartPresent};
            end
        end
        next_cur.irq = |(next_cur.status & next_cur.mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cur <= '{state: ST_EMPTY, cartPrev: 1'b0, rewPrev: 1'b1,
                posPrev: 1'b0, lowCnt: CNT_ZERO, status: EV_NONE,
                mask: EV_NONE, rdData: RD_ZERO, irq: 1'b0,
                readyLamp_n: 1'b1, writeLamp_n: 1'b1,
                writeTab: 1'b0, cartPresent: 1'b0,
                leaderAbsent_n: 1'b1, posSense: 1'b0,
                markPulse: 1'b0, fastSpeed_n: 1'b1,
                driveReady_n: 1'b1, reverseMotor: 1'b0,
                fwdGated: 1'b0, bwdGated: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------
    assign regRdData = cur.rdData;
    assign irq = cur.irq;
    assign ready_lamp_n = cur.readyLamp_n;
    assign write_lamp_level_n = cur.writeLamp_n;
    assign write_tab_level = cur.writeTab;
    assign cartridge_present = cur.cartPresent;
    assign leader_absent_n = cur.leaderAbsent_n;
    assign photo_position_sense = cur.posSense;
    assign mark_seen_pulse = cur.markPulse;
    assign fast_speed_n = cur.fastSpeed_n;
    assign drive_ready_n = cur.driveReady_n;
    assign reverse_motor_control = cur.reverseMotor;
    assign fwdDriveGated = cur.fwdGated;
    assign bwdDriveGated = cur.bwdGated;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_rev_not_ready: assert property (@(posedge ref_clk)
        disable iff (reset) reverse_motor_control |-> drive_ready_n)
        else $error("reverse motor while ready");
    chk_ready_lamp: assert property (@(posedge ref_clk)
        disable iff (reset)
        ready_lamp_n == $past(syncBus.hostReadyLamp_n))
        else $error("ready lamp not following host");
    chk_write_lamp: assert property (@(posedge ref_clk)
        disable iff (reset) write_lamp_level_n == !write_tab_level)
        else $error("write lamp mismatch");
    chk_tab_cart: assert property (@(posedge ref_clk)
        disable iff (reset) write_tab_level |-> cartridge_present)
        else $error("tab without cartridge");
    chk_leader_stop: assert property (@(posedge ref_clk)
        disable iff (reset)
        (cur.state == ST_REWIND && syncBus.leaderSeen
        && syncBus.cartPresent) |=> cur.state == ST_READY)
        else $error("rewind did not stop at leader");
    chk_pos_sense: assert property (@(posedge ref_clk)
        disable iff (reset)
        photo_position_sense == $past(posNow))
        else $error("position sense wrong");
    chk_no_drive_rew: assert property (@(posedge ref_clk)
        disable iff (reset) reverse_motor_control
        |-> !fwdDriveGated && !bwdDriveGated)
        else $error("drive during rewind");
    chk_deselect_idle: assert property (@(posedge ref_clk)
        disable iff (reset) $past(syncBus.unitSelect_n)
        |-> drive_ready_n && !reverse_motor_control)
        else $error("active while deselected");
    chk_load_rewind: assert property (@(posedge ref_clk)
        disable iff (reset) (cur.state == ST_EMPTY
        && syncBus.cartPresent && !syncBus.leaderSeen)
        |=> cur.state == ST_REWIND ##1 drive_ready_n)
        else $error("no rewind after load");
    chk_fast_speed: assert property (@(posedge ref_clk)
        disable iff (reset) !fast_speed_n
        |-> !$past(syncBus.fastSpeedReq_n))
        else $error("fast speed without request");
    chk_cart_level: assert property (@(posedge ref_clk)
        disable iff (reset) cartridge_present
        == $past(syncBus.cartPresent))
        else $error("cartridge level wrong");
    chk_leader_level: assert property (@(posedge ref_clk)
        disable iff (reset) leader_absent_n
        == !$past(syncBus.leaderSeen))
        else $error("leader level wrong");
    chk_mark_pulse: assert property (@(posedge ref_clk)
        disable iff (reset) mark_seen_pulse |-> photo_position_sense)
        else $error("mark without position sense");
    chk_ready_state: assert property (@(posedge ref_clk)
        disable iff (reset) !drive_ready_n
        |-> $past(cur.state == ST_READY || next_cur.state == ST_READY))
        else $error("ready outside ready state");
    chk_rew_edge: assert property (@(posedge ref_clk)
        disable iff (reset) (cur.state == ST_READY && rewEdge
        && syncBus.cartPresent && !syncBus.leaderSeen)
        |=> cur.state == ST_REWIND)
        else $error("rewind pulse ignored");
    // Deselected unit never asks for high speed
    chk_deselect_fast: assert property (@(posedge ref_clk)
        disable iff (reset) $past(syncBus.unitSelect_n) |-> fast_speed_n)
        else $error("fast speed while deselected");
endmodule : tape_rewind_ready_logic
`default_nettype wire

//--- verif/trr_tape_model.sv
// Model of the tape deck and the controlling device's rewind pulse
`default_nettype none
module trr_tape_model
    import trr_pkg::*;
#(
    parameter int LEADER_END = 50,
    parameter int HOLE_POS = 300,
    parameter int PULSE_CYC = 60
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic insert,
    input wire logic tabIn,
    input wire logic [9:0] loadPos,
    input wire logic pulseReq,
    input wire logic reverse_motor_control,
    input wire logic fwdDriveGated,
    input wire logic bwdDriveGated,
    output logic cartSense,
    output logic tabSense,
    output logic leaderSense,
    output logic holeSense,
    output logic rewind_pulse_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int pos; // Tape position, leader at the low end
    int pulseLeft; // Remaining cycles of the low pulse
    // Read retries and error classing stay with the host
    // ----------------------------------------
    // Tape motion
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pos <= 0;
        end else if (!insert) begin
            pos <= int'(loadPos);
        end else if ((reverse_motor_control || bwdDriveGated) && pos > 0) begin
            pos <= pos - 1;
        end else if (fwdDriveGated) begin
            pos <= pos + 1;
        end
    end
    // Low pulse of 0.6 us, inside the allowed span
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pulseLeft <= 0;
        end else if (pulseReq) begin
            pulseLeft <= PULSE_CYC;
        end else if (pulseLeft > 0) begin
            pulseLeft <= pulseLeft - 1;
        end
    end
    // ----------------------------------------
    // Sensor levels
    // ----------------------------------------
    always_comb begin
        cartSense = insert;
        tabSense = insert && tabIn;
        leaderSense = insert && (pos < LEADER_END);
        holeSense = insert && (pos >= HOLE_POS) && (pos < HOLE_POS + 4);
        rewind_pulse_n = (pulseLeft == 0);
    end
endmodule // trr_tape_model
`default_nettype wire

//--- verif/tb_top.sv
// Testbench: register port and pin scenarios for the rewind/ready logic
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import trr_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic insert = 1'b0, tabIn = 1'b1, pulseReq = 1'b0;
    logic [9:0] loadPos = 10'h190;
    logic cartSense, tabSense, leaderSense, holeSense, rewind_pulse_n;
    logic unit_select_n = 1'b0, host_ready_lamp_level_n = 1'b1;
    logic fast_speed_req_n = 1'b1, fwdReq_n = 1'b1, bwdReq_n = 1'b1;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWrData = 8'h00, rd;
    logic regWrite = 1'b0, regRead = 1'b0;
    logic [7:0] regRdData;
    logic irq, ready_lamp_n, write_lamp_level_n, write_tab_level;
    logic cartridge_present, leader_absent_n, photo_position_sense;
    logic mark_seen_pulse, fast_speed_n, drive_ready_n;
    logic reverse_motor_control, fwdDriveGated, bwdDriveGated;
    int error_cnt = 0, checked = 0, markCnt = 0;
    // ----------------------------------------
    // Clock, design and partner
    // ----------------------------------------
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    tape_rewind_ready_logic i_tape_rewind_ready_logic (.ref_clk(ref_clk),
        .reset(reset), .cartSense(cartSense), .tabSense(tabSense),
        .leaderSense(leaderSense), .holeSense(holeSense),
        .rewind_pulse_n(rewind_pulse_n), .unit_select_n(unit_select_n),
        .host_ready_lamp_level_n(host_ready_lamp_level_n),
        .fast_speed_req_n(fast_speed_req_n), .fwdReq_n(fwdReq_n),
        .bwdReq_n(bwdReq_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .irq(irq), .ready_lamp_n(ready_lamp_n),
        .write_lamp_level_n(write_lamp_level_n),
        .write_tab_level(write_tab_level),
        .cartridge_present(cartridge_present),
        .leader_absent_n(leader_absent_n),
        .photo_position_sense(photo_position_sense),
        .mark_seen_pulse(mark_seen_pulse), .fast_speed_n(fast_speed_n),
        .drive_ready_n(drive_ready_n),
        .reverse_motor_control(reverse_motor_control),
        .fwdDriveGated(fwdDriveGated), .bwdDriveGated(bwdDriveGated));
    trr_tape_model i_trr_tape_model (.ref_clk(ref_clk), .reset(reset),
        .insert(insert), .tabIn(tabIn), .loadPos(loadPos),
        .pulseReq(pulseReq), .reverse_motor_control(reverse_motor_control),
        .fwdDriveGated(fwdDriveGated), .bwdDriveGated(bwdDriveGated),
        .cartSense(cartSense), .tabSense(tabSense),
        .leaderSense(leaderSense), .holeSense(holeSense),
        .rewind_pulse_n(rewind_pulse_n));
    // Counts one-cycle mark pulses
    always @(posedge ref_clk) begin
        if (mark_seen_pulse === 1'b1) markCnt <= markCnt + 1;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk_byte(input string name, input logic [7:0] exp,
        input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic reg_rd(input logic [1:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        rd = regRdData;
    endtask
    // Bounded wait: sel 0 for ready level v, sel 1 for mark pulse level v
    task automatic wait_until(input int sel, input logic v);
        int n;
        for (n = 0; n < 2000; n++) begin
            if (sel == 0 ? drive_ready_n === v : mark_seen_pulse === v) break;
            cyc(1);
        end
        if (n == 2000) begin
            error_cnt++;
            $display("BAD wait %0d expected done seen timeout", sel);
            report_and_stop();
        end
    endtask
    task automatic pulse_host();
        @(posedge ref_clk);
        pulseReq <= 1'b1;
        @(posedge ref_clk);
        pulseReq <= 1'b0;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cyc(16);
        reset <= 1'b0;
        cyc(2);
        chk_bit("ready_n reset", 1'b1, drive_ready_n);
        chk_bit("irq reset", 1'b0, irq);
        chk_bit("leader reset", 1'b1, leader_absent_n);
        reg_rd(ADR_STATE);
        chk_byte("state reset", 8'h12, rd);
        reg_wr(2'h3, 8'hff);
        reg_rd(2'h3);
        chk_byte("unmapped", 8'h00, rd);
        reg_wr(ADR_MASK, 8'h0f);
        reg_rd(ADR_MASK);
        chk_byte("mask", 8'h0f, rd);
        // Load off leader: automatic rewind first
        insert <= 1'b1;
        cyc(6);
        chk_bit("cart", 1'b1, cartridge_present);
        chk_bit("tab", 1'b1, write_tab_level);
        chk_bit("wlamp", 1'b0, write_lamp_level_n);
        chk_bit("reverse", 1'b1, reverse_motor_control);
        chk_bit("ready_n rew", 1'b1, drive_ready_n);
        chk_bit("irq load", 1'b1, irq);
        reg_rd(ADR_STATE);
        chk_byte("state rew", 8'h27, rd);
        wait_until(0, 1'b0);
        chk_bit("reverse rdy", 1'b0, reverse_motor_control);
        chk_bit("leader", 1'b0, leader_absent_n);
        chk_bit("possense", 1'b1, photo_position_sense);
        chk_byte("marks rew", 8'h01, markCnt[7:0]);
        reg_rd(ADR_STATE);
        chk_byte("state rdy", 8'h41, rd);
        reg_rd(ADR_STATUS);
        chk_byte("status", 8'h05, rd & 8'h05);
        reg_wr(ADR_STATUS, 8'h0f);
        reg_rd(ADR_STATUS);
        chk_byte("status clr", 8'h00, rd);
        chk_bit("irq clr", 1'b0, irq);
        // Forward off leader past the position hole
        fwdReq_n <= 1'b0;
        wait_until(1, 1'b1);
        chk_bit("fwd on", 1'b1, fwdDriveGated);
        fwdReq_n <= 1'b1;
        chk_bit("leader off", 1'b1, leader_absent_n);
        // Host rewind with interrupts masked, drive requests refused
        reg_wr(ADR_MASK, 8'h00);
        reg_wr(ADR_STATUS, 8'h0f);
        pulse_host();
        cyc(8);
        chk_bit("host rew", 1'b1, reverse_motor_control);
        chk_bit("host rdy_n", 1'b1, drive_ready_n);
        fwdReq_n <= 1'b0;
        bwdReq_n <= 1'b0;
        cyc(5);
        chk_bit("fwd gated", 1'b0, fwdDriveGated);
        chk_bit("bwd gated", 1'b0, bwdDriveGated);
        fwdReq_n <= 1'b1;
        bwdReq_n <= 1'b1;
        wait_until(0, 1'b0);
        chk_bit("irq masked", 1'b0, irq);
        reg_rd(ADR_STATUS);
        chk_byte("rew event", 8'h02, rd & 8'h02);
        reg_wr(ADR_MASK, 8'h02);
        cyc(3);
        chk_bit("irq unmask", 1'b1, irq);
        reg_wr(ADR_STATUS, 8'h0f);
        cyc(3);
        chk_bit("irq gone", 1'b0, irq);
        // Deselected: outputs idle, pulse ignored, lamp still follows
        unit_select_n <= 1'b1;
        fast_speed_req_n <= 1'b0;
        host_ready_lamp_level_n <= 1'b0;
        cyc(5);
        chk_bit("desel rdy_n", 1'b1, drive_ready_n);
        chk_bit("desel fast", 1'b1, fast_speed_n);
        chk_bit("lamp", 1'b0, ready_lamp_n);
        pulse_host();
        cyc(80);
        unit_select_n <= 1'b0;
        cyc(5);
        chk_bit("sel rdy_n", 1'b0, drive_ready_n);
        chk_bit("no rew", 1'b0, reverse_motor_control);
        chk_bit("fast", 1'b0, fast_speed_n);
        host_ready_lamp_level_n <= 1'b1;
        cyc(5);
        chk_bit("lamp off", 1'b1, ready_lamp_n);
        // Removal
        insert <= 1'b0;
        cyc(5);
        chk_bit("cart out", 1'b0, cartridge_present);
        chk_bit("tab out", 1'b0, write_tab_level);
        chk_bit("wlamp off", 1'b1, write_lamp_level_n);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
